// [hdl/axl_user_access.sv]
// How it works
// - After reset the machine idles, goes to read on a read request, else to write on a write request, else stays.
// - The write phase presents address valid, address, data valid, data and byte strobes.
// - The write phase ends for acknowledge only when response valid and response ready are both high.
// - A slave-error write response raises the write error output.
// - The read phase presents address valid and the read address.
// - The read phase ends for acknowledge only when read valid and read ready are both high.
// - A slave-error read response raises the read error output.
// - The acknowledge state returns to idle on the next clock.
// - All logic resets synchronously to the clock while the active-low reset is low.
// - The write strobe is four bits, one per byte lane of write data.
// - Addresses and data are carried as 32-bit words.
// - Responses use a two-bit code: okay, exclusive okay, slave error, decode error.
// - Read ready is raised only while the read data can be taken that cycle.
// - Write data valid is high only while valid data and matching strobes are driven.
`timescale 1ns/100ps
module axl_user_access
  import axl_pkg::*;
(
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  user_read_req_in,
  input  wire logic                  user_write_req_in,
  input  wire axl_req_t              user_req_in,
  output axl_rsp_t                   user_rsp_out,
  output logic                       user_ack_out,
  output logic                       user_busy_out,
  output logic [AXL_ADDR_W-1:0]      m_axi_awaddr_out,
  output logic                       m_axi_awvalid_out,
  input  wire logic                  m_axi_awready_in,
  output logic [AXL_DATA_W-1:0]      m_axi_wdata_out,
  output logic [AXL_STRB_W-1:0]      m_axi_wstrb_out,
  output logic                       m_axi_wvalid_out,
  input  wire logic                  m_axi_wready_in,
  input  wire logic [AXL_RESP_W-1:0] m_axi_bresp_in,
  input  wire logic                  m_axi_bvalid_in,
  output logic                       m_axi_bready_out,
  output logic [AXL_ADDR_W-1:0]      m_axi_araddr_out,
  output logic                       m_axi_arvalid_out,
  input  wire logic                  m_axi_arready_in,
  input  wire logic [AXL_DATA_W-1:0] m_axi_rdata_in,
  input  wire logic [AXL_RESP_W-1:0] m_axi_rresp_in,
  input  wire logic                  m_axi_rvalid_in,
  output logic                       m_axi_rready_out
);

  // Both slave-error and decode-error count as failures; a decode error
  // means nobody owns the address, which the user must also hear about.
  function automatic logic resp_is_err(input logic [AXL_RESP_W-1:0] resp);
    resp_is_err = 1'b0;
    unique case (resp)
      AXL_RESP_OKAY:   resp_is_err = 1'b0;
      AXL_RESP_EXOKAY: resp_is_err = 1'b0;
      AXL_RESP_SLVERR: resp_is_err = 1'b1;
      AXL_RESP_DECERR: resp_is_err = 1'b1;
    endcase
  endfunction

  axl_state_t state_ff;
  axl_state_t nxt_state;
  axl_req_t   req_ff;
  axl_req_t   nxt_req;
  axl_rsp_t   rsp_ff;
  axl_rsp_t   nxt_rsp;
  logic       start_wr;
  logic       start_rd;
  logic       b_done;
  logic       r_done;

  // The ready, ack and busy outputs decode the state register directly, so a ready is
  // up for the whole phase, even before the address has been accepted.
  always_comb begin
    m_axi_bready_out = 1'b0;
    m_axi_rready_out = 1'b0;
    user_ack_out     = 1'b0;
    user_busy_out    = 1'b1;
    unique case (state_ff)
      AXL_ST_IDLE: begin
        user_busy_out = 1'b0;
      end
      AXL_ST_WRITE: begin
        m_axi_bready_out = 1'b1;
      end
      AXL_ST_READ: begin
        m_axi_rready_out = 1'b1;
      end
      AXL_ST_ACK: begin
        user_ack_out = 1'b1;
      end
    endcase
  end

  assign b_done = m_axi_bvalid_in && m_axi_bready_out;
  assign r_done = m_axi_rvalid_in && m_axi_rready_out;

  // Reads win over writes when both are requested in the same cycle.
  // Requests are only looked at in idle; one raised while busy is dropped
  // without notice, so the user waits for the ack before asking again.
  assign start_rd = (state_ff == AXL_ST_IDLE) && user_read_req_in;
  assign start_wr = (state_ff == AXL_ST_IDLE) && !user_read_req_in
                    && user_write_req_in;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      AXL_ST_IDLE: begin
        if (user_read_req_in) begin
          nxt_state = AXL_ST_READ;
        end else if (user_write_req_in) begin
          nxt_state = AXL_ST_WRITE;
        end
      end
      AXL_ST_WRITE: begin
        if (b_done) begin
          nxt_state = AXL_ST_ACK;
        end
      end
      AXL_ST_READ: begin
        if (r_done) begin
          nxt_state = AXL_ST_ACK;
        end
      end
      AXL_ST_ACK: begin
        nxt_state = AXL_ST_IDLE;
      end
    endcase
  end

  // Reset is sampled on the clock like any other input, so the machine
  // and the three valid holds leave reset together on one edge.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_ff <= AXL_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The request is latched once so the bus payload cannot move while
  // a valid is pending, whatever the user does with its own inputs.
  always_comb begin
    nxt_req = req_ff;
    if (start_rd || start_wr) begin
      nxt_req = user_req_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      req_ff.addr <= AXL_ADDR_RST;
      req_ff.data <= AXL_DATA_RST;
      req_ff.strb <= AXL_STRB_RST;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // Each error flag holds from its completing handshake until the next
  // request of its own kind is accepted, so it can be read alongside the ack pulse.
  // A clear and a capture never meet in one cycle: requests are taken
  // only in idle and completions only inside a phase.
  always_comb begin
    nxt_rsp = rsp_ff;
    if (start_wr) begin
      nxt_rsp.wr_err = 1'b0;
    end
    if (start_rd) begin
      nxt_rsp.rd_err = 1'b0;
    end
    if (b_done) begin
      nxt_rsp.wr_err = resp_is_err(m_axi_bresp_in);
    end
    if (r_done) begin
      nxt_rsp.rdata  = m_axi_rdata_in;
      nxt_rsp.rd_err = resp_is_err(m_axi_rresp_in);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rsp_ff.rdata  <= AXL_DATA_RST;
      rsp_ff.wr_err <= 1'b0;
      rsp_ff.rd_err <= 1'b0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  // Each channel keeps its own valid because the slave may accept address
  // and data in either order; a shared valid would repeat one of them.
  axl_valid_hold u_aw_hold (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .start_in    (start_wr),
    .ready_in    (m_axi_awready_in),
    .valid_out   (m_axi_awvalid_out)
  );

  axl_valid_hold u_w_hold (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .start_in    (start_wr),
    .ready_in    (m_axi_wready_in),
    .valid_out   (m_axi_wvalid_out)
  );

  axl_valid_hold u_ar_hold (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .start_in    (start_rd),
    .ready_in    (m_axi_arready_in),
    .valid_out   (m_axi_arvalid_out)
  );

  // Payload comes straight from the latched request, never from the user.
  assign m_axi_awaddr_out = req_ff.addr;
  assign m_axi_araddr_out = req_ff.addr;
  assign m_axi_wdata_out  = req_ff.data;
  assign m_axi_wstrb_out  = req_ff.strb;

  assign user_rsp_out = rsp_ff;

endmodule

// [hdl/axl_pkg.sv]
package axl_pkg;

  localparam int unsigned AXL_ADDR_W = 32;
  localparam int unsigned AXL_DATA_W = 32;
  localparam int unsigned AXL_STRB_W = 4;
  localparam int unsigned AXL_RESP_W = 2;

  localparam logic [AXL_RESP_W-1:0] AXL_RESP_OKAY   = 2'h0;
  localparam logic [AXL_RESP_W-1:0] AXL_RESP_EXOKAY = 2'h1;
  localparam logic [AXL_RESP_W-1:0] AXL_RESP_SLVERR = 2'h2;
  localparam logic [AXL_RESP_W-1:0] AXL_RESP_DECERR = 2'h3;

  localparam logic [AXL_ADDR_W-1:0] AXL_ADDR_RST = 32'h0000_0000;
  localparam logic [AXL_DATA_W-1:0] AXL_DATA_RST = 32'h0000_0000;
  localparam logic [AXL_STRB_W-1:0] AXL_STRB_RST = 4'h0;

  typedef enum logic [1:0] {
    AXL_ST_IDLE  = 2'b00,
    AXL_ST_WRITE = 2'b01,
    AXL_ST_READ  = 2'b10,
    AXL_ST_ACK   = 2'b11
  } axl_state_t;

  // One user request: address, write data and byte lanes.
  typedef struct packed {
    logic [AXL_ADDR_W-1:0] addr;
    logic [AXL_DATA_W-1:0] data;
    logic [AXL_STRB_W-1:0] strb;
  } axl_req_t;

  // Completion seen by the user: read data and the two error levels.
  typedef struct packed {
    logic [AXL_DATA_W-1:0] rdata;
    logic                  wr_err;
    logic                  rd_err;
  } axl_rsp_t;

endpackage

// [hdl/axl_valid_hold.sv]
`timescale 1ns/100ps
module axl_valid_hold
  import axl_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic start_in,
  input  wire logic ready_in,
  output logic      valid_out
);

  logic valid_ff;
  logic nxt_valid;

  // Valid rises on start and stays until the slave's ready is seen.
  always_comb begin
    nxt_valid = valid_ff;
    if (start_in) begin
      nxt_valid = 1'b1;
    end else if (valid_ff && ready_in) begin
      nxt_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  assign valid_out = valid_ff;

endmodule

// [verification/axl_user_access_assertions.sv]
`timescale 1ns/100ps
module axl_user_access_assertions
  import axl_pkg::*;
(
  input wire logic                  core_clk_in,
  input wire logic                  reset_n_in,
  input wire logic                  user_read_req_in,
  input wire logic                  user_write_req_in,
  input wire logic                  user_ack_out,
  input wire logic                  user_busy_out,
  input wire logic [AXL_ADDR_W-1:0] m_axi_awaddr_out,
  input wire logic                  m_axi_awvalid_out,
  input wire logic                  m_axi_awready_in,
  input wire logic [AXL_DATA_W-1:0] m_axi_wdata_out,
  input wire logic [AXL_STRB_W-1:0] m_axi_wstrb_out,
  input wire logic                  m_axi_wvalid_out,
  input wire logic                  m_axi_wready_in,
  input wire logic                  m_axi_bvalid_in,
  input wire logic                  m_axi_bready_out,
  input wire logic [AXL_ADDR_W-1:0] m_axi_araddr_out,
  input wire logic                  m_axi_arvalid_out,
  input wire logic                  m_axi_arready_in,
  input wire logic                  m_axi_rvalid_in,
  input wire logic                  m_axi_rready_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_bhs;
    m_axi_bvalid_in && m_axi_bready_out;
  endsequence
  sequence s_rhs;
    m_axi_rvalid_in && m_axi_rready_out;
  endsequence
  sequence s_done;
    user_ack_out ##1 !(user_busy_out || user_ack_out);
  endsequence
  property p_rd_first;
    !user_busy_out && user_read_req_in |=>
      m_axi_arvalid_out && m_axi_rready_out && !m_axi_awvalid_out;
  endproperty
  property p_wr_start;
    !user_busy_out && !user_read_req_in && user_write_req_in |=>
      m_axi_awvalid_out && m_axi_wvalid_out && m_axi_bready_out;
  endproperty
  property p_idle_stay;
    !user_busy_out && !user_read_req_in && !user_write_req_in |=>
      !user_busy_out;
  endproperty
  property p_b_wait;
    m_axi_bready_out && !m_axi_bvalid_in |=> !user_ack_out;
  endproperty
  property p_r_wait;
    m_axi_rready_out && !m_axi_rvalid_in |=> !user_ack_out;
  endproperty
  property p_aw_hold;
    m_axi_awvalid_out && !m_axi_awready_in |=>
      m_axi_awvalid_out && $stable(m_axi_awaddr_out);
  endproperty
  property p_w_hold;
    m_axi_wvalid_out && !m_axi_wready_in |=> m_axi_wvalid_out &&
      $stable(m_axi_wdata_out) && $stable(m_axi_wstrb_out);
  endproperty
  property p_ar_hold;
    m_axi_arvalid_out && !m_axi_arready_in |=>
      m_axi_arvalid_out && $stable(m_axi_araddr_out);
  endproperty
  property p_rready;
    m_axi_rready_out |-> user_busy_out && !user_ack_out && !m_axi_bready_out;
  endproperty
  AST_RD_FIRST: assert property (p_rd_first)
    else $error("read request did not open a read");
  AST_WR_START: assert property (p_wr_start)
    else $error("write request did not open a write");
  AST_IDLE_STAY: assert property (p_idle_stay)
    else $error("left idle without a request");
  AST_B_ACK: assert property (s_bhs |=> s_done)
    else $error("write response not acknowledged");
  AST_B_WAIT: assert property (p_b_wait)
    else $error("write acknowledged early");
  AST_R_ACK: assert property (s_rhs |=> s_done)
    else $error("read response not acknowledged");
  AST_R_WAIT: assert property (p_r_wait)
    else $error("read acknowledged early");
  AST_AW_HOLD: assert property (p_aw_hold)
    else $error("write address valid or address moved early");
  AST_W_HOLD: assert property (p_w_hold)
    else $error("write data valid, data or strobes moved early");
  AST_AR_HOLD: assert property (p_ar_hold)
    else $error("read address valid or address moved early");
  AST_RREADY_PHASE: assert property (p_rready)
    else $error("read ready raised outside the read phase");
endmodule
bind axl_user_access axl_user_access_assertions
  axl_user_access_assertions_inst (.*);

// [verification/axl_slave_model.sv]
`timescale 1ns/100ps
module axl_slave_model
  import axl_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic [3:0]  slow_in,
  input  wire logic [31:0] m_axi_awaddr_out,
  input  wire logic        m_axi_awvalid_out,
  input  wire logic [31:0] m_axi_wdata_out,
  input  wire logic [3:0]  m_axi_wstrb_out,
  input  wire logic        m_axi_wvalid_out,
  input  wire logic        m_axi_bready_out,
  input  wire logic [31:0] m_axi_araddr_out,
  input  wire logic        m_axi_arvalid_out,
  input  wire logic        m_axi_rready_out,
  output logic             m_axi_awready_in = 1'b0,
  output logic             m_axi_wready_in = 1'b0,
  output logic [1:0]       m_axi_bresp_in = 2'h0,
  output logic             m_axi_bvalid_in = 1'b0,
  output logic             m_axi_arready_in = 1'b0,
  output logic [31:0]      m_axi_rdata_in = 32'h0,
  output logic [1:0]       m_axi_rresp_in = 2'h0,
  output logic             m_axi_rvalid_in = 1'b0
);
  // Four words at the bottom of the map; anything else is an error.
  logic [31:0] mem [4] = '{default: 32'h0};
  logic        w_bad;
  logic        r_bad;
  assign w_bad = |m_axi_awaddr_out[31:4];
  assign r_bad = |m_axi_araddr_out[31:4];
  always begin
    @(posedge core_clk_in);
    if (m_axi_awvalid_out && m_axi_wvalid_out) begin
      repeat (slow_in) @(posedge core_clk_in);
      m_axi_awready_in <= 1'b1;
      m_axi_wready_in <= 1'b1;
      @(posedge core_clk_in);
      m_axi_awready_in <= 1'b0;
      m_axi_wready_in <= 1'b0;
      m_axi_bvalid_in <= 1'b1;
      m_axi_bresp_in <= w_bad ? AXL_RESP_SLVERR : AXL_RESP_OKAY;
      for (int i = 0; i < 4; i++)
        if (m_axi_wstrb_out[i] && !w_bad)
          mem[m_axi_awaddr_out[3:2]][i*8+:8] <= m_axi_wdata_out[i*8+:8];
      do @(posedge core_clk_in); while (!m_axi_bready_out);
      m_axi_bvalid_in <= 1'b0;
      m_axi_bresp_in <= ~m_axi_bresp_in;
    end
  end
  always begin
    @(posedge core_clk_in);
    if (m_axi_arvalid_out) begin
      repeat (slow_in) @(posedge core_clk_in);
      m_axi_arready_in <= 1'b1;
      @(posedge core_clk_in);
      m_axi_arready_in <= 1'b0;
      m_axi_rvalid_in <= 1'b1;
      m_axi_rdata_in <= mem[m_axi_araddr_out[3:2]];
      m_axi_rresp_in <= r_bad ? AXL_RESP_SLVERR : AXL_RESP_OKAY;
      do @(posedge core_clk_in); while (!m_axi_rready_out);
      m_axi_rvalid_in <= 1'b0;
      m_axi_rdata_in <= ~m_axi_rdata_in;
      m_axi_rresp_in <= ~m_axi_rresp_in;
    end
  end
endmodule

// [verification/test_axl_user_access.sv]
`timescale 1ns/100ps
module test_axl_user_access import axl_pkg::*;;
  logic core_clk_in, reset_n_in, user_read_req_in, user_write_req_in;
  logic user_ack_out, user_busy_out, m_axi_awvalid_out, m_axi_awready_in;
  logic m_axi_wvalid_out, m_axi_wready_in, m_axi_bvalid_in, m_axi_bready_out;
  logic m_axi_arvalid_out, m_axi_arready_in, m_axi_rvalid_in, m_axi_rready_out;
  logic [31:0] m_axi_awaddr_out, m_axi_wdata_out;
  logic [31:0] m_axi_araddr_out, m_axi_rdata_in;
  logic [3:0]  m_axi_wstrb_out, slow_in;
  logic [1:0]  m_axi_bresp_in, m_axi_rresp_in;
  axl_req_t    user_req_in;
  axl_rsp_t    user_rsp_out;
  int          error_cnt, compares;
  axl_user_access axl_user_access_inst (.*);
  axl_slave_model axl_slave_model_inst (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One request, then wait a bounded time for the acknowledge cycle.
  task automatic xfer(input logic rd, wr, input logic [31:0] a, d,
                      input logic [3:0] s);
    int n;
    @(posedge core_clk_in);
    user_read_req_in <= rd;
    user_write_req_in <= wr;
    user_req_in <= '{a, d, s};
    @(posedge core_clk_in);
    user_read_req_in <= 1'b0;
    user_write_req_in <= 1'b0;
    for (n = 0; n < 40 && user_ack_out !== 1'b1; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    if (n == 40) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic t_data;
    xfer(1'b0, 1'b1, 32'h4, 32'hA1B2C3D4, 4'hF);
    xfer(1'b0, 1'b1, 32'h4, 32'h55667788, 4'h5);
    xfer(1'b1, 1'b0, 32'h4, 32'h0, 4'h0);
    chk(user_rsp_out.rdata, 32'hA166C388);
  endtask
  task automatic t_err;
    xfer(1'b0, 1'b1, 32'h100, 32'h1, 4'hF);
    chk(user_rsp_out.wr_err, 1'b1);
    xfer(1'b1, 1'b0, 32'h200, 32'h0, 4'h0);
    chk(user_rsp_out.rd_err, 1'b1);
    xfer(1'b1, 1'b0, 32'h0, 32'h0, 4'h0);
    chk({user_rsp_out.wr_err, user_rsp_out.rd_err}, 2'h2);
  endtask
  // Both requests together: the read wins and the word stays untouched.
  task automatic t_prio;
    xfer(1'b1, 1'b1, 32'h8, 32'hDEADBEEF, 4'hF);
    xfer(1'b1, 1'b0, 32'h8, 32'h0, 4'h0);
    chk(user_rsp_out.rdata, 32'h0);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  initial begin
    {reset_n_in, user_read_req_in, user_write_req_in} = 3'h0;
    user_req_in = '0;
    slow_in = 4'h0;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk({user_busy_out, user_ack_out, m_axi_awvalid_out,
         m_axi_arvalid_out, m_axi_bready_out}, 5'h0);
    t_data();
    t_err();
    t_prio();
    @(posedge core_clk_in);
    slow_in <= 4'h3;
    t_data();
    t_err();
    results();
  end
endmodule
